// ### logic/scdp_consts.vh
// Constants for the spectrometer configuration and data-set port.
`ifndef SCDP_CONSTS_VH
`define SCDP_CONSTS_VH
`define SCDP_SYNC_BYTE 8'hfd
`define SCDP_TERM_BYTE 8'hff
`define SCDP_REQ_DUMP 8'h65
`define SCDP_REQ_DUMP_CLR 8'h66
`define SCDP_BLOCK_BYTES 7'h40
`define SCDP_CFG_BYTES 64
`define SCDP_BF_FAST_PEAK 0
`define SCDP_BF_OFFSET 1
`define SCDP_BF_POL 3
`define SCDP_BF_CLK80 4
`define SCDP_BF_BAUD 5
`define SCDP_BF_NVCFG 6
`define SCDP_BF_EMUL 7
`define SCDP_BF_MINMAX 8
`define SCDP_BF_FASTSRC 9
`define SCDP_BF_DEFINED 16'h03ff
`define SCDP_CLK_HZ 40000000
`define SCDP_BAUD_LO 57600
`define SCDP_BAUD_HI 115200
`define SCDP_REG_BOOT 8'h00
`define SCDP_REG_STAT 8'h01
`define SCDP_REG_CFG_BASE 8'h40
`define SCDP_FT_NS 200
`define SCDP_PK_NS 800
`define SCDP_FASTPK_NS 16'h0190
`define SCDP_LOCK_SLOW_US 16'h3336
`define SCDP_LOCK_FAST_US 16'h0333
`endif

// ### logic/scdp_port.v
// Command decoder, boot flags, configuration fields and data-set dump.
`timescale 1ns/1ps
`include "scdp_consts.vh"
// Notes on behaviour
// - Request is three bytes: sync 0xfd, packet number, terminator 0xff.
// - 0x65 dumps the data set; 0x66 dumps it and clears spectrum.
// - Dump order: spectrum, 64-byte status block, 64-byte configuration.
// - Each channel three bytes, low byte first, channels ascending.
// - Boot flag D5 picks 57,600 or 115,200 baud.
// - D15-D8 clear at power-up; D7-D0 restored from nonvolatile copy.
// - Flags other than D4, D1 apply at reset; D4, D1 at next config.
// - D9 selects histogram source: slow channel or fast channel; the code holds fast_src_o at 0.
// - D8 selects maxima only, or maxima and minima capture; the code holds minmax_o at 0.
// - D7 selects emulation: packet or stored bias/cooler values.
// - D6 selects unconfigured boot or stored configuration boot.
// - D4 selects 20 or 80 MHz; timings follow scale factor.
// - D3 declares bias polarity; jumpers checked before supply enable.
// - D1 forces spectrum offset zero or applies programmed offset.
// - D0 selects normal or four times slower fast peaking time.
// - Byte 0 holds flat top code and decimation exponent.
// - Byte 6 high nibble holds peaking code one to eight.
// - Byte 4 D5 enables histogram; D4-D2 select channel count.
// - Byte 4 routes output DAC; byte 3 signed offset and enable.
// - Pileup reject is on whenever byte 5 is nonzero.
// - Byte 6 D3-D2 lockout length scaled; D0 suspends histogram.
module scdp_port #(
	parameter CHAN_AW = 13
) (
	// Clock and reset.
	input wire sys_clk_i,
	input wire rst_n_i,
	// Serial link, byte level.
	input wire rx_valid_i,
	input wire [7:0] rx_byte_i,
	input wire tx_ready_i,
	output reg tx_valid_o,
	output reg [7:0] tx_byte_o,
	// Spectrum memory read port, data one cycle after address.
	output reg [CHAN_AW-1:0] spec_addr_o,
	input wire [23:0] spec_data_i,
	output reg spec_clear_o,
	// Status block read port, data one cycle after index.
	output reg [5:0] stat_idx_o,
	input wire [7:0] stat_data_i,
	// Nonvolatile boot flag image and board jumper.
	input wire [7:0] nv_flags_i,
	input wire pol_jumper_i,
	input wire supply_req_i,
	output reg supply_en_o,
	output reg pol_fault_o,
	// Register port.
	input wire [7:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	// Decoded controls.
	output reg [15:0] baud_div_o,
	output reg clk80_o,
	output reg offset_en_o,
	output reg fast_src_o,
	output reg minmax_o,
	output reg emul_nv_o,
	output reg nv_cfg_o,
	output reg fast_peak_slow_o,
	output reg [3:0] flat_top_o,
	output reg [2:0] decim_o,
	output reg [3:0] peak_code_o,
	output reg hist_en_o,
	output reg [2:0] chan_sel_o,
	output reg [1:0] dac_route_o,
	output reg [6:0] dac_offset_o,
	output reg dac_en_o,
	output reg pileup_reject_o,
	output reg [1:0] lockout_sel_o,
	output reg lockout_keep_hist_o,
	output reg [15:0] lockout_us_o,
	output reg [15:0] fast_peak_ns_o
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_NUM = 3'h1;
	localparam [2:0] ST_TERM = 3'h2;
	localparam [2:0] ST_SPEC = 3'h3;
	localparam [2:0] ST_STAT = 3'h4;
	localparam [2:0] ST_CFG = 3'h5;
	// Divisors are worked out wide, then cut to the port width.
	localparam [31:0] DIV_LO_W = `SCDP_CLK_HZ / `SCDP_BAUD_LO;
	localparam [31:0] DIV_HI_W = `SCDP_CLK_HZ / `SCDP_BAUD_HI;
	localparam [15:0] DIV_LO = DIV_LO_W[15:0];
	localparam [15:0] DIV_HI = DIV_HI_W[15:0];

	// Channel count as last index for a channel select code.
	function [CHAN_AW-1:0] last_chan;
		input [2:0] sel;
		begin
			case (sel)
			3'h1: last_chan = 13'h07ff;
			3'h2: last_chan = 13'h03ff;
			3'h3: last_chan = 13'h01ff;
			3'h4: last_chan = 13'h00ff;
			3'h5: last_chan = 13'h1fff;
			default: last_chan = 13'h0fff;
			endcase
		end
	endfunction

	reg [2:0] st_q;
	reg [7:0] num_q;
	reg [15:0] boot_q;
	reg boot_ld_q;
	reg [7:0] cfg_q [0:63];
	reg [CHAN_AW-1:0] chan_q;
	reg [1:0] bsel_q;
	reg [5:0] idx_q;
	reg fetch_q;
	reg [23:0] word_q;
	reg jump_s1_q;
	reg jump_s2_q;
	reg clear_pend_q;
	reg pol_req_q;
	// Byte lanes of the configuration store and the write decode.
	wire [7:0] c0 = cfg_q[0];
	wire [7:0] c3 = cfg_q[3];
	wire [7:0] c4 = cfg_q[4];
	wire [7:0] c5 = cfg_q[5];
	wire [7:0] c6 = cfg_q[6];
	wire cfg_wr = reg_wr_i && (reg_addr_i[7:6] == 2'b01);
	wire cfg_done = cfg_wr && (reg_addr_i[5:0] == 6'h3f);
	wire tx_go = !tx_valid_o || tx_ready_i;
	integer i;

	// Boot flags: high half volatile, low half from nonvolatile image.
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boot_q <= 16'h0000;
			boot_ld_q <= 1'b0;
			pol_req_q <= 1'b0;
		end else if (!boot_ld_q) begin
			boot_q <= {8'h00, nv_flags_i};
			boot_ld_q <= 1'b1;
			pol_req_q <= nv_flags_i[`SCDP_BF_POL];
		end else if (reg_wr_i && reg_addr_i == `SCDP_REG_BOOT) begin
			boot_q <= reg_wdata_i & `SCDP_BF_DEFINED;
		end
	end

	// Configuration packet store, written by byte index.
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (i = 0; i < `SCDP_CFG_BYTES; i = i + 1)
				cfg_q[i] <= 8'h00;
		end else if (cfg_wr) begin
			cfg_q[reg_addr_i[5:0]] <= reg_wdata_i[7:0];
		end
	end

	// Flags held from reset only, and live flags taken at config end.
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			baud_div_o <= DIV_LO;
			fast_src_o <= 1'b0;
			minmax_o <= 1'b0;
			emul_nv_o <= 1'b0;
			nv_cfg_o <= 1'b0;
			fast_peak_slow_o <= 1'b0;
			clk80_o <= 1'b0;
			offset_en_o <= 1'b0;
		end else begin
			if (!boot_ld_q) begin
				// Reset-time flags follow the image latched at release.
				baud_div_o <= nv_flags_i[`SCDP_BF_BAUD] ?
					DIV_HI : DIV_LO;
				emul_nv_o <= nv_flags_i[`SCDP_BF_EMUL];
				nv_cfg_o <= nv_flags_i[`SCDP_BF_NVCFG];
				fast_peak_slow_o <= nv_flags_i[`SCDP_BF_FAST_PEAK];
				clk80_o <= nv_flags_i[`SCDP_BF_CLK80];
				offset_en_o <= nv_flags_i[`SCDP_BF_OFFSET];
				fast_src_o <= 1'b0;
				minmax_o <= 1'b0;
			// Live flags follow the written boot word once byte 63 lands.
			end else if (cfg_done) begin
				clk80_o <= boot_q[`SCDP_BF_CLK80];
				offset_en_o <= boot_q[`SCDP_BF_OFFSET];
			end
		end
	end

	// Configuration field decode and clock-scaled times.
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flat_top_o <= 4'h0;
			decim_o <= 3'h0;
			peak_code_o <= 4'h0;
			hist_en_o <= 1'b0;
			chan_sel_o <= 3'h0;
			dac_route_o <= 2'h0;
			dac_offset_o <= 7'h00;
			dac_en_o <= 1'b0;
			pileup_reject_o <= 1'b0;
			lockout_sel_o <= 2'h0;
			lockout_keep_hist_o <= 1'b0;
			lockout_us_o <= 16'h0000;
			fast_peak_ns_o <= 16'h0000;
		end else begin
			flat_top_o <= c0[6:3];
			decim_o <= c0[2:0];
			peak_code_o <= c6[7:4];
			hist_en_o <= c4[5];
			chan_sel_o <= c4[4:2];
			dac_route_o <= c4[1:0];
			dac_offset_o <= c3[7:1];
			dac_en_o <= c3[0];
			pileup_reject_o <= (c5 != 8'h00);
			lockout_sel_o <= c6[3:2];
			lockout_keep_hist_o <= c6[0];
			// Halve per code step, then divide by scale factor.
			lockout_us_o <= ((c0[7] ? `SCDP_LOCK_FAST_US :
				`SCDP_LOCK_SLOW_US) >> c6[3:2])
				>> (clk80_o ? 2 : 0);
			fast_peak_ns_o <= (`SCDP_FASTPK_NS << (fast_peak_slow_o ? 2 : 0))
				>> (clk80_o ? 2 : 0);
			// Histogram source and peak capture keep their boot values.
		end
	end

	// Bias polarity check before any supply is enabled.
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			jump_s1_q <= 1'b0;
			jump_s2_q <= 1'b0;
			supply_en_o <= 1'b0;
			pol_fault_o <= 1'b0;
		end else begin
			jump_s1_q <= pol_jumper_i;
			jump_s2_q <= jump_s1_q;
			// Polarity comes from the boot copy, so a later write cannot unlock.
			pol_fault_o <= boot_ld_q &&
				(jump_s2_q != pol_req_q);
			supply_en_o <= supply_req_i && boot_ld_q &&
				(jump_s2_q == pol_req_q);
		end
	end

	// Register reads: boot flags, status, configuration bytes.
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_rd_i) begin
			if (reg_addr_i == `SCDP_REG_BOOT)
				reg_rdata_o <= boot_q;
			else if (reg_addr_i == `SCDP_REG_STAT)
				reg_rdata_o <= {12'h000, st_q, pol_fault_o};
			else if (reg_addr_i[7:6] == 2'b01)
				reg_rdata_o <= {8'h00, cfg_q[reg_addr_i[5:0]]};
			else
				reg_rdata_o <= 16'h0000;
		end
	end

	// Request parser and data-set sender.
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ST_IDLE;
			num_q <= 8'h00;
			chan_q <= {CHAN_AW{1'b0}};
			bsel_q <= 2'h0;
			idx_q <= 6'h00;
			fetch_q <= 1'b0;
			word_q <= 24'h000000;
			tx_valid_o <= 1'b0;
			tx_byte_o <= 8'h00;
			spec_addr_o <= {CHAN_AW{1'b0}};
			spec_clear_o <= 1'b0;
			stat_idx_o <= 6'h00;
			clear_pend_q <= 1'b0;
		end else begin
			spec_clear_o <= 1'b0;
			if (tx_valid_o && tx_ready_i)
				tx_valid_o <= 1'b0;
			case (st_q)
			// Bytes before a sync byte are ignored.
			ST_IDLE: begin
				if (rx_valid_i && rx_byte_i == `SCDP_SYNC_BYTE)
					st_q <= ST_NUM;
			end
			ST_NUM: begin
				if (rx_valid_i) begin
					num_q <= rx_byte_i;
					st_q <= ST_TERM;
				end
			end
			// Anything but a dump request with a clean terminator is dropped.
			ST_TERM: begin
				if (rx_valid_i) begin
					if (rx_byte_i == `SCDP_TERM_BYTE &&
						(num_q == `SCDP_REQ_DUMP ||
						num_q == `SCDP_REQ_DUMP_CLR)) begin
						st_q <= ST_SPEC;
						clear_pend_q <= (num_q == `SCDP_REQ_DUMP_CLR);
						chan_q <= {CHAN_AW{1'b0}};
						spec_addr_o <= {CHAN_AW{1'b0}};
						bsel_q <= 2'h0;
						fetch_q <= 1'b1;
					end else begin
						st_q <= ST_IDLE;
					end
				end
			end
			ST_SPEC: begin
				if (fetch_q) begin
					// Address went out last edge; its data land on this one.
					fetch_q <= 1'b0;
				end else if (tx_go) begin
					tx_valid_o <= 1'b1;
					if (bsel_q == 2'h0) begin
						tx_byte_o <= spec_data_i[7:0];
						word_q <= {8'h00, spec_data_i[23:8]};
					end else begin
						tx_byte_o <= word_q[7:0];
						word_q <= {8'h00, word_q[23:8]};
					end
					if (bsel_q != 2'h2) begin
						bsel_q <= bsel_q + 2'h1;
					end else if (chan_q == last_chan(chan_sel_o)) begin
						st_q <= ST_STAT;
						idx_q <= 6'h00;
						stat_idx_o <= 6'h00;
						fetch_q <= 1'b1;
					end else begin
						bsel_q <= 2'h0;
						chan_q <= chan_q + 1'b1;
						spec_addr_o <= chan_q + 1'b1;
						fetch_q <= 1'b1;
					end
				end
			end
			// Status data follow the index by one edge, hence the fetch cycle.
			ST_STAT: begin
				if (fetch_q) begin
					fetch_q <= 1'b0;
				end else if (tx_go) begin
					tx_valid_o <= 1'b1;
					tx_byte_o <= stat_data_i;
					idx_q <= idx_q + 6'h01;
					stat_idx_o <= idx_q + 6'h01;
					fetch_q <= 1'b1;
					if (idx_q == 6'h3f) begin
						st_q <= ST_CFG;
						fetch_q <= 1'b0;
					end
				end
			end
			// Configuration bytes come straight from the store with no wait.
			ST_CFG: begin
				if (tx_go) begin
					tx_valid_o <= 1'b1;
					tx_byte_o <= cfg_q[idx_q];
					idx_q <= idx_q + 6'h01;
					if (idx_q == 6'h3f) begin
						st_q <= ST_IDLE;
						spec_clear_o <= clear_pend_q;
						clear_pend_q <= 1'b0;
					end
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule

// ### sim/scdp_port_properties.sv
// Concurrent checks on the port block, bound to every instance of it.
`timescale 1ns/1ps
module scdp_chk (
	// Clock, reset and transmit side.
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire tx_ready_i,
	input wire tx_valid_o,
	input wire [7:0] tx_byte_o,
	input wire spec_clear_o,
	// Boot image, supply gate and decoded flags.
	input wire [7:0] nv_flags_i,
	input wire supply_req_i,
	input wire supply_en_o,
	input wire pol_fault_o,
	input wire [15:0] baud_div_o,
	input wire clk80_o,
	input wire fast_src_o,
	input wire minmax_o,
	input wire emul_nv_o,
	input wire nv_cfg_o,
	input wire fast_peak_slow_o,
	input wire [15:0] fast_peak_ns_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// Boot-time outputs are judged from the third edge after reset.
	sequence s_up;
		$past(rst_n_i, 2);
	endsequence
	// A byte offered while the host holds ready low.
	sequence s_stall;
		tx_valid_o && !tx_ready_i;
	endsequence
	// The live clock flag has held since the previous edge.
	sequence s_steady;
		$past(rst_n_i, 2) && $stable(clk80_o);
	endsequence
	AST_TX_HOLD: assert property (
		s_stall |=> tx_valid_o && $stable(tx_byte_o))
		else $error("tx byte moved while stalled");
	AST_CLR_PULSE: assert property (
		spec_clear_o |=> !spec_clear_o)
		else $error("spectrum clear longer than one cycle");
	AST_POL_BLOCK: assert property (
		pol_fault_o |-> !supply_en_o)
		else $error("supply enabled with polarity fault");
	AST_SUPPLY_OFF: assert property (
		!supply_req_i [*2] |-> !supply_en_o)
		else $error("supply enabled without request");
	AST_BAUD: assert property (
		s_up |-> baud_div_o == (nv_flags_i[5] ? 16'h015b : 16'h02b6))
		else $error("baud divisor wrong");
	AST_BOOT: assert property (
		s_up |-> {emul_nv_o, nv_cfg_o} == nv_flags_i[7:6])
		else $error("boot-time flags differ from image");
	AST_VOL: assert property (
		s_up |-> !fast_src_o && !minmax_o)
		else $error("volatile flag active after boot");
	AST_FAST_PK: assert property (
		s_steady |-> fast_peak_ns_o == ((clk80_o ? 16'h0064 : 16'h0190)
		<< (fast_peak_slow_o ? 2 : 0)))
		else $error("fast peaking time wrong");
endmodule

bind scdp_port scdp_chk u_chk (.*);

// ### sim/scdp_host_model.sv
// Host model: sends request frames and sinks the returned bytes.
`timescale 1ns/1ps
module scdp_host_model (
	// Clock and device transmit side.
	input wire sys_clk_i,
	input wire tx_valid_o,
	input wire [7:0] tx_byte_o,
	// Request bytes and receive handshake.
	output logic rx_valid_i = 1'h0,
	output logic [7:0] rx_byte_i = 8'h00,
	output logic tx_ready_i = 1'h1
);
	logic slow_mode = 1'h0;
	logic [7:0] got_q [$];
	// Take each accepted byte; slow mode drops ready every other cycle.
	always @(posedge sys_clk_i) begin
		if (tx_valid_o && tx_ready_i)
			got_q.push_back(tx_byte_o);
		tx_ready_i <= slow_mode ? ~tx_ready_i : 1'h1;
	end
	// One strobe per byte with a gap; an idle line shows the inverse.
	task automatic send(input logic [7:0] b0, b1, b2);
		logic [7:0] f [3];
		f = '{b0, b1, b2};
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk_i);
			rx_valid_i <= 1'h1;
			rx_byte_i <= f[i];
			@(posedge sys_clk_i);
			rx_valid_i <= 1'h0;
			rx_byte_i <= ~f[i];
		end
	endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the configuration and data-set port.
`timescale 1ns/1ps
module testbench;
	logic sys_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0;
	logic pol_jumper_i = 1'h0;
	logic supply_req_i = 1'h0;
	logic [7:0] nv_flags_i = 8'h00;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] stat_data_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [23:0] spec_data_i = 24'h000000;
	wire rx_valid_i, tx_ready_i, tx_valid_o, spec_clear_o, supply_en_o;
	wire pol_fault_o, clk80_o, offset_en_o, fast_src_o, minmax_o, emul_nv_o;
	wire nv_cfg_o, fast_peak_slow_o, hist_en_o, dac_en_o, pileup_reject_o;
	wire lockout_keep_hist_o;
	wire [1:0] dac_route_o, lockout_sel_o;
	wire [2:0] decim_o, chan_sel_o;
	wire [3:0] flat_top_o, peak_code_o;
	wire [5:0] stat_idx_o;
	wire [6:0] dac_offset_o;
	wire [7:0] rx_byte_i, tx_byte_o;
	wire [12:0] spec_addr_o;
	wire [15:0] reg_rdata_o, baud_div_o, lockout_us_o, fast_peak_ns_o;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	int clears = 0;
	logic [7:0] cfgm [64];
	logic [15:0] rv;

	scdp_port DUT (.*);
	scdp_host_model host (.*);

	// Spectrum memory content; the low and top bytes of a channel always differ.
	function automatic logic [23:0] spec_of(input logic [12:0] c);
		return {c[7:0] ^ 8'ha5, 3'h0, c[12:8], c[7:0]};
	endfunction
	// Free-running system clock.
	initial begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	// Memories answer one cycle late; a hung run is cut short.
	always @(posedge sys_clk_i) begin
		spec_data_i <= spec_of(spec_addr_o);
		stat_data_i <= {2'h2, stat_idx_o};
		cycles <= cycles + 1;
		if (spec_clear_o)
			clears <= clears + 1;
		if (cycles == 60000) begin
			err_total++;
			close_out();
		end
	end
	// Count a comparison and report a mismatch.
	task automatic chk(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Register bus write and read; read data are taken in the next cycle.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h0;
		@(negedge sys_clk_i);
		d = reg_rdata_o;
	endtask
	// Reset with a given nonvolatile image, held four cycles.
	task automatic do_reset(input logic [7:0] nv);
		@(posedge sys_clk_i);
		rst_n_i <= 1'h0;
		nv_flags_i <= nv;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'h1;
		repeat (4) @(posedge sys_clk_i);
	endtask
	// Write all configuration bytes; the last one commits the live boot flags.
	task automatic load_cfg();
		for (int i = 0; i < 64; i++)
			wr(8'h40 + 8'(i), {8'h00, cfgm[i]});
		repeat (3) @(posedge sys_clk_i);
	endtask
	// Request a dump and compare spectrum, status and configuration.
	task automatic dump(input logic [7:0] num, input int nch, input logic sl);
		int s = nch * 3;
		int n = s + 128;
		logic [7:0] e;
		clears = 0;
		host.got_q.delete();
		host.slow_mode = sl;
		host.send(8'hfd, num, 8'hff);
		for (int t = 0; t < 8 * n && host.got_q.size() < n; t++)
			@(posedge sys_clk_i);
		repeat (20) @(posedge sys_clk_i);
		chk("dump length", n, host.got_q.size());
		chk("clear pulses", num == 8'h66, clears);
		for (int i = 0; i < host.got_q.size(); i++) begin
			if (i >= s + 64)
				e = cfgm[i - s - 64];
			else if (i >= s)
				e = {2'h2, 6'(i - s)};
			else
				e = 8'(spec_of(13'(i / 3)) >> (8 * (i % 3)));
			chk("dump byte", e, host.got_q[i]);
		end
	endtask
	// Power-up state with an empty image; unmapped reads give zero.
	task automatic t_defaults();
		chk("baud divisor", 16'h02b6, baud_div_o);
		rd(8'h00, rv);
		chk("boot flags", 16'h0000, rv);
		rd(8'h20, rv);
		chk("unmapped read", 16'h0000, rv);
	endtask
	// Live offset flag waits for the packet; fields decode; 0x66 dump.
	task automatic t_cfg_a();
		for (int i = 0; i < 64; i++)
			cfgm[i] = 8'(i * 7);
		cfgm[0] = 8'haa;
		cfgm[3] = 8'hfb;
		cfgm[5] = 8'h80;
		cfgm[6] = 8'h31;
		cfgm[4] = 8'h32;
		wr(8'h00, 16'h0002);
		rd(8'h00, rv);
		chk("boot flags", 16'h0002, rv);
		chk("offset enable", 1'h0, offset_en_o);
		load_cfg();
		chk("offset enable", 1'h1, offset_en_o);
		chk("shaping", 11'h2a3, {flat_top_o, decim_o, peak_code_o});
		chk("dac", 9'h1fb, {hist_en_o, dac_offset_o, dac_en_o});
		chk("pileup", 1'h1, pileup_reject_o);
		chk("lockout", 17'h00667, {lockout_us_o, lockout_keep_hist_o});
		dump(8'h66, 256, 1'h1);
	endtask
	// Frames with a bad sync, terminator or number get no answer.
	task automatic t_bad();
		logic [23:0] f [3] = '{24'hfe65ff, 24'hfd65fe, 24'hfd10ff};
		for (int i = 0; i < 3; i++) begin
			host.got_q.delete();
			host.send(f[i][23:16], f[i][15:8], f[i][7:0]);
			repeat (40) @(posedge sys_clk_i);
			chk("reply bytes", 0, host.got_q.size());
		end
	endtask
	// Every channel count and DAC route code, checked after byte 4 and then byte 63 are written.
	task automatic t_codes();
		for (int k = 0; k < 6; k++) begin
			wr(8'h44, {11'h000, 3'(k), 2'(k)});
			wr(8'h7f, {8'h00, cfgm[63]});
			repeat (3) @(posedge sys_clk_i);
			chk("count and route", {3'(k), 2'(k)}, {chan_sel_o, dac_route_o});
		end
	endtask
	// Live clock flag, volatile flags set, fields cleared; 0x65 dump.
	task automatic t_cfg_b();
		cfgm[0] = 8'h0b;
		cfgm[3] = 8'h02;
		cfgm[4] = 8'h0f;
		cfgm[5] = 8'h00;
		cfgm[6] = 8'h8c;
		wr(8'h00, 16'h0310);
		chk("clock select", 1'h0, clk80_o);
		load_cfg();
		chk("clock select", 1'h1, clk80_o);
		chk("offset enable", 1'h0, offset_en_o);
		chk("shaping", 11'h0b8, {flat_top_o, decim_o, peak_code_o});
		chk("dac", 9'h002, {hist_en_o, dac_offset_o, dac_en_o});
		chk("pileup", 1'h0, pileup_reject_o);
		chk("lockout select", 3'h6, {lockout_sel_o, lockout_keep_hist_o});
		dump(8'h65, 512, 1'h0);
	endtask
	// Mid-run reset keeps only the low flags; polarity gates the supply.
	task automatic t_boot();
		pol_jumper_i <= 1'h1;
		supply_req_i <= 1'h1;
		do_reset(8'he9);
		rd(8'h00, rv);
		chk("boot flags", 16'h00e9, rv);
		chk("baud divisor", 16'h015b, baud_div_o);
		chk("fast peak", 16'h0640, fast_peak_ns_o);
		chk("supply", 1'h1, supply_en_o);
		pol_jumper_i <= 1'h0;
		repeat (6) @(posedge sys_clk_i);
		chk("supply and fault", 2'h1, {supply_en_o, pol_fault_o});
		rd(8'h01, rv);
		chk("status", 16'h0001, rv);
		supply_req_i <= 1'h0;
	endtask
	// Print the counts and the verdict, then stop.
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		do_reset(8'h00);
		t_defaults();
		t_cfg_a();
		t_bad();
		t_codes();
		t_cfg_b();
		t_boot();
		close_out();
	end
endmodule
